// ---- verilog/dmp_pkg.sv ----
package dmp_pkg;

  localparam int DATA_W = 16;
  localparam int OP_W = 17;
  localparam int PROD_W = 32;
  localparam int ACC_W = 40;
  localparam int ADDR_W = 16;

  localparam int SRC_SHIFT = 16;
  localparam logic [15:0] PTR_STEP_PAIR = 16'h0002;
  localparam logic [15:0] PTR_STEP_ONE = 16'h0001;
  localparam logic [2:0] SIZE_SHORT = 3'h4;
  localparam logic [2:0] SIZE_LONG = 3'h5;

  localparam logic [16:0] OP_MINUS_ONE = 17'h18000;
  localparam logic [31:0] PROD_SAT_POS = 32'h7FFFFFFF;
  localparam logic [40:0] RND_BIAS = 41'h00000008000;
  localparam logic [15:0] RND_TIE = 16'h8000;
  localparam int RND_LSB = 16;
  localparam logic [39:0] SAT40_POS = 40'h7FFFFFFFFF;
  localparam logic [39:0] SAT40_NEG = 40'h8000000000;
  localparam logic [39:0] SAT32_POS = 40'h007FFFFFFF;
  localparam logic [39:0] SAT32_NEG = 40'hFF80000000;
  localparam logic [39:0] ACC_RESET = 40'h0000000000;
  localparam logic [15:0] PTR_RESET = 16'h0000;

  typedef enum logic [2:0] {
    FORM_XY_COEF = 3'h1,
    FORM_S_HILO = 3'h2,
    FORM_S_HILO_SH = 3'h3,
    FORM_L_HILO = 3'h4,
    FORM_L_HILO_SH = 3'h5,
    FORM_YX_HILO_SH = 3'h6
  } dmp_form_e;

endpackage

// ---- verilog/dmp_mult_unit.sv ----
`timescale 1ns/100ps
module dmp_mult_unit
  import dmp_pkg::*;
(
  input wire logic [15:0] data_in,
  input wire logic [15:0] coef_in,
  input wire logic data_uns_in,
  input wire logic coef_uns_in,
  input wire logic sign_extension_mode_bit_in,
  input wire logic fractional_mode_bit_in,
  input wire logic multiply_saturation_mode_in,
  output logic [39:0] product_out
);

  logic [16:0] data_op;
  logic [16:0] coef_op;
  logic signed [33:0] prod_raw;
  logic [34:0] prod_shift;
  logic [31:0] prod_32;

  // ****************************************************************
  // Operand widening and product
  // ****************************************************************
  always_comb begin
    // Data follows the sign mode; the coefficient is always sign filled unless unsigned.
    data_op = data_uns_in ? {1'b0, data_in} :
      {data_in[15] & sign_extension_mode_bit_in, data_in};
    coef_op = coef_uns_in ? {1'b0, coef_in} : {coef_in[15], coef_in};
    prod_raw = $signed(data_op) * $signed(coef_op);
    prod_shift = fractional_mode_bit_in ? {prod_raw, 1'b0} : {prod_raw[33], prod_raw};
    if (multiply_saturation_mode_in && fractional_mode_bit_in &&
        data_op == OP_MINUS_ONE && coef_op == OP_MINUS_ONE) begin
      prod_32 = PROD_SAT_POS;
    end else begin
      prod_32 = prod_shift[31:0];
    end
    product_out = {{(ACC_W - PROD_W){prod_32[31]}}, prod_32};
  end

endmodule

// ---- verilog/dmp_dual_mac.sv ----
`timescale 1ns/100ps
module dmp_dual_mac
  import dmp_pkg::*;
(
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic instr_valid_in,
  input wire logic [2:0] instr_form_in,
  input wire logic instr_paired_in,
  input wire logic round_opt_in,
  input wire logic forty_opt_in,
  input wire logic uns_mac_data_in,
  input wire logic uns_mac_coef_in,
  input wire logic uns_mpy_data_in,
  input wire logic uns_mpy_coef_in,
  input wire logic mac_disable_in,
  input wire logic mpy_disable_in,
  input wire logic coef_post_inc_in,
  input wire logic fractional_mode_bit_in,
  input wire logic multiply_saturation_mode_in,
  input wire logic sign_extension_mode_bit_in,
  input wire logic forty_bit_mode_bit_in,
  input wire logic rounding_mode_bit_in,
  input wire logic saturation_mode_bit_in,
  input wire logic [15:0] x_data_in,
  input wire logic [15:0] y_data_in,
  input wire logic [15:0] data_read_bus_d_in,
  input wire logic [15:0] lmem_high_in,
  input wire logic [15:0] lmem_low_in,
  input wire logic [15:0] coefficient_bus_in,
  input wire logic [15:0] coefficient_bus_high_in,
  input wire logic [15:0] coefficient_bus_low_in,
  input wire logic coefficient_pointer_load_in,
  input wire logic [15:0] coefficient_pointer_value_in,
  input wire logic acc_load_a_in,
  input wire logic acc_load_b_in,
  input wire logic [39:0] acc_load_value_in,
  input wire logic clear_flag_a_in,
  input wire logic clear_flag_b_in,
  output logic [39:0] accumulator_a_out,
  output logic [39:0] accumulator_b_out,
  output logic overflow_flag_dest_a_out,
  output logic overflow_flag_dest_b_out,
  output logic [15:0] coefficient_pointer_out,
  output logic [15:0] coef_addr_high_out,
  output logic [15:0] coef_addr_low_out,
  output logic instr_done_out,
  output logic [2:0] instr_size_out,
  output logic instr_reject_out
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [39:0] acc_reg [2];
  logic [39:0] acc_next [2];
  logic flag_reg [2];
  logic flag_next [2];
  logic [15:0] ptr_reg;
  logic [15:0] ptr_next;
  logic [15:0] addr_high_reg;
  logic [15:0] addr_high_next;
  logic [15:0] addr_low_reg;
  logic [15:0] addr_low_next;
  logic done_reg;
  logic done_next;
  logic reject_reg;
  logic reject_next;
  logic [2:0] size_reg;
  logic [2:0] size_next;

  logic form_ok;
  logic accept;
  logic forty_mode_eff;
  logic form_single;
  logic form_long;
  logic form_shift;
  logic [15:0] lane_data [2];
  logic [15:0] lane_coef [2];
  logic lane_data_uns [2];
  logic lane_coef_uns [2];
  logic lane_accum [2];
  logic lane_shift [2];
  logic lane_dest [2];
  logic lane_enable [2];
  logic [39:0] lane_result [2];
  logic lane_ovf [2];

  // ****************************************************************
  // Instruction decode
  // ****************************************************************
  always_comb begin
    form_single = 1'b0;
    form_long = 1'b0;
    form_shift = 1'b0;
    form_ok = 1'b1;
    case (instr_form_in)
      FORM_XY_COEF: begin
        form_single = 1'b0;
      end
      FORM_S_HILO: begin
        form_single = 1'b1;
      end
      FORM_S_HILO_SH: begin
        form_single = 1'b1;
        form_shift = 1'b1;
      end
      FORM_L_HILO: begin
        form_long = 1'b1;
      end
      FORM_L_HILO_SH: begin
        form_long = 1'b1;
        form_shift = 1'b1;
      end
      FORM_YX_HILO_SH: begin
        form_shift = 1'b1;
      end
      default: begin
        form_ok = 1'b0;
      end
    endcase
    // A dual-operation word fills both slots, so a paired request is refused.
    accept = instr_valid_in && form_ok && !instr_paired_in;
    forty_mode_eff = forty_bit_mode_bit_in | forty_opt_in;
  end

  // ****************************************************************
  // Operand routing to the two lanes
  // ****************************************************************
  // Lane 0 is the first multiplier unit (accumulating), lane 1 the second (multiply only).
  always_comb begin
    lane_data_uns[0] = uns_mac_data_in;
    lane_coef_uns[0] = uns_mac_coef_in;
    lane_data_uns[1] = uns_mpy_data_in;
    lane_coef_uns[1] = uns_mpy_coef_in;
    lane_accum[0] = 1'b1;
    lane_accum[1] = 1'b0;
    lane_shift[0] = form_shift;
    lane_shift[1] = 1'b0;
    lane_enable[0] = accept && !mac_disable_in;
    lane_enable[1] = accept && !mpy_disable_in;
    if (instr_form_in == FORM_XY_COEF) begin
      lane_data[0] = x_data_in;
      lane_data[1] = y_data_in;
      lane_coef[0] = coefficient_bus_in;
      lane_coef[1] = coefficient_bus_in;
      lane_dest[0] = 1'b0;
      lane_dest[1] = 1'b1;
    end else begin
      lane_coef[0] = coefficient_bus_high_in;
      lane_coef[1] = coefficient_bus_low_in;
      lane_dest[0] = 1'b1;
      lane_dest[1] = 1'b0;
      if (form_single) begin
        lane_data[0] = data_read_bus_d_in;
        lane_data[1] = data_read_bus_d_in;
      end else if (form_long) begin
        lane_data[0] = lmem_high_in;
        lane_data[1] = lmem_low_in;
      end else begin
        lane_data[0] = y_data_in;
        lane_data[1] = x_data_in;
      end
    end
  end

  // ****************************************************************
  // Per-lane arithmetic
  // ****************************************************************
  // Both lanes are purely combinational in the same cycle, so the pair retires together.
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_lane
      logic [39:0] product;
      logic [39:0] src;
      logic [39:0] src_adj;
      logic [40:0] sum;
      logic [40:0] rnd;
      logic ovf;
      logic [39:0] res;

      dmp_mult_unit u_mult (
        .data_in(lane_data[gi]),
        .coef_in(lane_coef[gi]),
        .data_uns_in(lane_data_uns[gi]),
        .coef_uns_in(lane_coef_uns[gi]),
        .sign_extension_mode_bit_in(sign_extension_mode_bit_in),
        .fractional_mode_bit_in(fractional_mode_bit_in),
        .multiply_saturation_mode_in(multiply_saturation_mode_in),
        .product_out(product)
      );

      always_comb begin
        src = acc_reg[lane_dest[gi]];
        // Bit 39 is the sign carried down by the right shift.
        src_adj = lane_shift[gi] ? 40'($signed(src) >>> SRC_SHIFT) : src;
        if (!lane_accum[gi]) begin
          src_adj = ACC_RESET;
        end
        sum = {src_adj[39], src_adj} + {product[39], product};
        rnd = sum;
        if (round_opt_in) begin
          rnd = sum + RND_BIAS;
          if (rounding_mode_bit_in && sum[15:0] == RND_TIE) begin
            rnd[RND_LSB] = 1'b0;
          end
          rnd[15:0] = 16'h0000;
        end
        if (forty_mode_eff) begin
          ovf = rnd[40] != rnd[39];
        end else begin
          ovf = !((&rnd[40:31]) || !(|rnd[40:31]));
        end
        res = rnd[39:0];
        if (ovf && saturation_mode_bit_in) begin
          if (forty_mode_eff) begin
            res = rnd[40] ? SAT40_NEG : SAT40_POS;
          end else begin
            res = rnd[40] ? SAT32_NEG : SAT32_POS;
          end
        end
        lane_result[gi] = res;
        lane_ovf[gi] = ovf;
      end
    end
  endgenerate

  // ****************************************************************
  // Accumulators and overflow flags
  // ****************************************************************
  always_comb begin
    for (int k = 0; k < 2; k++) begin
      acc_next[k] = acc_reg[k];
      flag_next[k] = flag_reg[k];
    end
    if (acc_load_a_in) begin
      acc_next[0] = acc_load_value_in;
    end
    if (acc_load_b_in) begin
      acc_next[1] = acc_load_value_in;
    end
    if (clear_flag_a_in) begin
      flag_next[0] = 1'b0;
    end
    if (clear_flag_b_in) begin
      flag_next[1] = 1'b0;
    end
    // The datapath write comes last so it wins over a load or a flag clear.
    for (int k = 0; k < 2; k++) begin
      if (lane_enable[k]) begin
        acc_next[lane_dest[k]] = lane_result[k];
        if (lane_ovf[k]) begin
          flag_next[lane_dest[k]] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      acc_reg[0] <= ACC_RESET;
      acc_reg[1] <= ACC_RESET;
      flag_reg[0] <= 1'b0;
      flag_reg[1] <= 1'b0;
    end else begin
      acc_reg[0] <= acc_next[0];
      acc_reg[1] <= acc_next[1];
      flag_reg[0] <= flag_next[0];
      flag_reg[1] <= flag_next[1];
    end
  end

  // ****************************************************************
  // Coefficient pointer and paired addresses
  // ****************************************************************
  always_comb begin
    ptr_next = ptr_reg;
    if (coefficient_pointer_load_in) begin
      ptr_next = coefficient_pointer_value_in;
    end else if (accept && coef_post_inc_in) begin
      // The pointer moves even when a lane is disabled.
      if (instr_form_in == FORM_XY_COEF) begin
        ptr_next = ptr_reg + PTR_STEP_ONE;
      end else begin
        ptr_next = ptr_reg + PTR_STEP_PAIR;
      end
    end
    addr_high_next = ptr_next;
    // Flipping bit zero gives +1 for an even address and -1 for an odd one.
    addr_low_next = {ptr_next[15:1], ~ptr_next[0]};
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      ptr_reg <= PTR_RESET;
      addr_high_reg <= PTR_RESET;
      addr_low_reg <= PTR_STEP_ONE;
    end else begin
      ptr_reg <= ptr_next;
      addr_high_reg <= addr_high_next;
      addr_low_reg <= addr_low_next;
    end
  end

  // ****************************************************************
  // Completion, size and refusal reporting
  // ****************************************************************
  always_comb begin
    done_next = accept;
    reject_next = instr_valid_in && !accept;
    size_next = size_reg;
    if (accept) begin
      size_next = (instr_form_in == FORM_YX_HILO_SH) ? SIZE_LONG : SIZE_SHORT;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      done_reg <= 1'b0;
      reject_reg <= 1'b0;
      size_reg <= 3'h0;
    end else begin
      done_reg <= done_next;
      reject_reg <= reject_next;
      size_reg <= size_next;
    end
  end

  assign accumulator_a_out = acc_reg[0];
  assign accumulator_b_out = acc_reg[1];
  assign overflow_flag_dest_a_out = flag_reg[0];
  assign overflow_flag_dest_b_out = flag_reg[1];
  assign coefficient_pointer_out = ptr_reg;
  assign coef_addr_high_out = addr_high_reg;
  assign coef_addr_low_out = addr_low_reg;
  assign instr_done_out = done_reg;
  assign instr_size_out = size_reg;
  assign instr_reject_out = reject_reg;

endmodule

// ---- sim/dmp_dual_mac_asserts.sv ----
`timescale 1ns/100ps
module dmp_dual_mac_asserts (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic instr_valid_in,
  input wire logic [2:0] instr_form_in,
  input wire logic instr_paired_in,
  input wire logic mac_disable_in,
  input wire logic mpy_disable_in,
  input wire logic coef_post_inc_in,
  input wire logic coefficient_pointer_load_in,
  input wire logic [15:0] coefficient_pointer_value_in,
  input wire logic acc_load_a_in,
  input wire logic acc_load_b_in,
  input wire logic clear_flag_a_in,
  input wire logic [39:0] accumulator_a_out,
  input wire logic [39:0] accumulator_b_out,
  input wire logic overflow_flag_dest_a_out,
  input wire logic [15:0] coefficient_pointer_out,
  input wire logic [15:0] coef_addr_high_out,
  input wire logic [15:0] coef_addr_low_out,
  input wire logic instr_done_out,
  input wire logic [2:0] instr_size_out,
  input wire logic instr_reject_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (srst_in);
  logic ok;
  assign ok = instr_valid_in && !instr_paired_in && instr_form_in != 3'h0 && instr_form_in != 3'h7;
  done_pulse_a: assert property (ok |=> instr_done_out && !instr_reject_out)
    else $error("accepted instruction gave no done pulse");
  reject_pulse_a: assert property (instr_valid_in && !ok |=> instr_reject_out && !instr_done_out)
    else $error("refused instruction gave no reject pulse");
  instr_size_a: assert property (ok |=> instr_size_out == (($past(instr_form_in) == 3'h6) ? 3'h5 : 3'h4))
    else $error("instruction size wrong");
  pair_addr_a: assert property (coef_addr_low_out == (coef_addr_high_out ^ 16'h0001)
    && coef_addr_high_out == coefficient_pointer_out)
    else $error("coefficient addresses not paired");
  ptr_step_a: assert property (ok && coef_post_inc_in && !coefficient_pointer_load_in && instr_form_in != 3'h1
    |=> coefficient_pointer_out == $past(coefficient_pointer_out) + 16'h0002)
    else $error("pointer did not advance by two");
  ptr_load_a: assert property (coefficient_pointer_load_in
    |=> coefficient_pointer_out == $past(coefficient_pointer_value_in))
    else $error("pointer load lost");
  lane_off_a: assert property (ok && mac_disable_in && mpy_disable_in && !acc_load_a_in && !acc_load_b_in
    |=> $stable(accumulator_a_out) && $stable(accumulator_b_out))
    else $error("disabled lanes wrote an accumulator");
  flag_hold_a: assert property (overflow_flag_dest_a_out && !clear_flag_a_in |=> overflow_flag_dest_a_out)
    else $error("overflow flag dropped without clear");
endmodule
bind dmp_dual_mac dmp_dual_mac_asserts dmp_dual_mac_asserts_i (.*);

// ---- sim/dmp_coef_mem.sv ----
`timescale 1ns/100ps
module dmp_coef_mem (
  input wire logic valid_in,
  input wire logic [15:0] addr_high_in,
  input wire logic [15:0] addr_low_in,
  output logic [15:0] coef_out,
  output logic [15:0] coef_high_out,
  output logic [15:0] coef_low_out
);
  logic [15:0] mem_arr [256];
  initial for (int i = 0; i < 256; i++) mem_arr[i] = 16'(i * 40503) ^ 16'h8000;
  // Outside an instruction the buses show the inverse, so stale data is never mistaken for a fetch.
  always_comb begin
    coef_out = valid_in ? mem_arr[addr_high_in[7:0]] : ~mem_arr[addr_high_in[7:0]];
    coef_high_out = valid_in ? mem_arr[addr_high_in[7:0]] : ~mem_arr[addr_high_in[7:0]];
    coef_low_out = valid_in ? mem_arr[addr_low_in[7:0]] : ~mem_arr[addr_low_in[7:0]];
  end
endmodule

// ---- sim/tb.sv ----
`timescale 1ns/100ps
module tb;
  import dmp_pkg::*;
  logic clk_in = 0, srst_in = 1;
  logic instr_valid_in, instr_paired_in, round_opt_in, forty_opt_in;
  logic uns_mac_data_in, uns_mac_coef_in, uns_mpy_data_in, uns_mpy_coef_in;
  logic mac_disable_in, mpy_disable_in, coef_post_inc_in, fractional_mode_bit_in;
  logic multiply_saturation_mode_in, sign_extension_mode_bit_in, forty_bit_mode_bit_in;
  logic rounding_mode_bit_in, saturation_mode_bit_in, coefficient_pointer_load_in;
  logic acc_load_a_in, acc_load_b_in, clear_flag_a_in, clear_flag_b_in;
  logic [2:0] instr_form_in, instr_size_out;
  logic [15:0] x_data_in, y_data_in, data_read_bus_d_in, lmem_high_in, lmem_low_in;
  logic [15:0] coefficient_bus_in, coefficient_bus_high_in, coefficient_bus_low_in;
  logic [15:0] coefficient_pointer_value_in, coefficient_pointer_out, coef_addr_high_out, coef_addr_low_out;
  logic [39:0] acc_load_value_in, accumulator_a_out, accumulator_b_out;
  logic overflow_flag_dest_a_out, overflow_flag_dest_b_out, instr_done_out, instr_reject_out;
  logic [39:0] ea = 0, eb = 0;
  logic [15:0] ep = 0;
  logic [2:0] es = 0;
  bit fa, fb, ed, er, forty_eff;
  int err_count, checked, cyc;
  dmp_dual_mac dmp_dual_mac_i (.*);
  dmp_coef_mem dmp_coef_mem_i (.valid_in(instr_valid_in), .addr_high_in(coef_addr_high_out),
    .addr_low_in(coef_addr_low_out), .coef_out(coefficient_bus_in),
    .coef_high_out(coefficient_bus_high_in), .coef_low_out(coefficient_bus_low_in));
  always #2 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 2500) begin
      err_count++;
      wrap_up();
    end
  end
  // **********
  // Reference model.
  // **********
  function automatic logic [39:0] lane(input logic [39:0] src, input logic [15:0] d, c,
      input bit ud, uc, sh, ac, output bit ov);
    longint a, b, p, s;
    bit t;
    a = (ud || !sign_extension_mode_bit_in) ? longint'(d) : longint'($signed(d));
    b = uc ? longint'(c) : longint'($signed(c));
    p = a * b;
    if (fractional_mode_bit_in) p = p <<< 1;
    if (multiply_saturation_mode_in && fractional_mode_bit_in && a == -32768 && b == -32768) p = 32'h7FFFFFFF;
    s = longint'($signed(p[31:0]));
    if (ac) s += sh ? longint'($signed(src)) >>> 16 : longint'($signed(src));
    t = s[15:0] == 16'h8000;
    if (round_opt_in) s = (s + 32'h8000) & ~64'hFFFF;
    if (round_opt_in && rounding_mode_bit_in && t) s[16] = 1'b0;
    ov = forty_eff ? s[40] != s[39] : s[40:31] != 10'h000 && s[40:31] != 10'h3FF;
    if (ov && saturation_mode_bit_in) begin
      if (forty_eff) return s[40] ? SAT40_NEG : SAT40_POS;
      return s[40] ? SAT32_NEG : SAT32_POS;
    end
    return s[39:0];
  endfunction
  task automatic put(input bit to_b, input logic [39:0] r, input bit o);
    if (to_b) begin
      eb = r;
      fb |= o;
    end else begin
      ea = r;
      fa |= o;
    end
  endtask
  task automatic predict();
    bit ok, o0, o1;
    logic [2:0] f;
    logic [15:0] c0, c1, d0, d1;
    logic [39:0] r0, r1;
    f = instr_form_in;
    ok = instr_valid_in && !instr_paired_in && f != 3'h0 && f != 3'h7;
    forty_eff = forty_bit_mode_bit_in || forty_opt_in;
    c0 = dmp_coef_mem_i.mem_arr[ep[7:0]];
    c1 = f == 3'h1 ? c0 : dmp_coef_mem_i.mem_arr[ep[7:0] ^ 8'h01];
    d0 = f == 3'h1 ? x_data_in : f == 3'h6 ? y_data_in : f > 3'h3 ? lmem_high_in : data_read_bus_d_in;
    d1 = f == 3'h1 ? y_data_in : f == 3'h6 ? x_data_in : f > 3'h3 ? lmem_low_in : data_read_bus_d_in;
    r0 = lane(f == 3'h1 ? ea : eb, d0, c0, uns_mac_data_in, uns_mac_coef_in, f == 3 || f == 5 || f == 6, 1, o0);
    r1 = lane(ea, d1, c1, uns_mpy_data_in, uns_mpy_coef_in, 0, 0, o1);
    if (acc_load_a_in) ea = acc_load_value_in;
    if (acc_load_b_in) eb = acc_load_value_in;
    if (clear_flag_a_in) fa = 0;
    if (clear_flag_b_in) fb = 0;
    if (ok && !mac_disable_in) put(f != 3'h1, r0, o0);
    if (ok && !mpy_disable_in) put(f == 3'h1, r1, o1);
    if (coefficient_pointer_load_in) ep = coefficient_pointer_value_in;
    else if (ok && coef_post_inc_in) ep += f == 3'h1 ? PTR_STEP_ONE : PTR_STEP_PAIR;
    if (ok) es = f == 3'h6 ? SIZE_LONG : SIZE_SHORT;
    ed = ok;
    er = instr_valid_in && !ok;
    if (srst_in) {ea, eb, ep, es, fa, fb, ed, er} = '0;
  endtask
  // **********
  // Stimulus and comparison.
  // **********
  function automatic logic [15:0] r16();
    // The extreme negative value and zero are favoured to reach saturation and empty products.
    case ($urandom_range(3))
      0: return 16'h8000;
      1: return 16'h0000;
      default: return 16'($urandom);
    endcase
  endfunction
  task automatic drive(input bit go);
    {round_opt_in, forty_opt_in, uns_mac_data_in, uns_mac_coef_in, uns_mpy_data_in, uns_mpy_coef_in,
      coef_post_inc_in, fractional_mode_bit_in, multiply_saturation_mode_in, sign_extension_mode_bit_in,
      forty_bit_mode_bit_in, rounding_mode_bit_in, saturation_mode_bit_in} = 13'($urandom);
    mac_disable_in = $urandom_range(7) == 0;
    mpy_disable_in = $urandom_range(7) == 0;
    instr_valid_in = go && $urandom_range(7) != 0;
    instr_form_in = 3'($urandom);
    instr_paired_in = $urandom_range(15) == 0;
    {coefficient_pointer_load_in, acc_load_a_in, acc_load_b_in, clear_flag_a_in, clear_flag_b_in} =
      go ? 5'($urandom & $urandom & $urandom) : 5'h00;
    coefficient_pointer_value_in = 16'($urandom);
    acc_load_value_in = {8'($urandom), 32'($urandom)};
    x_data_in = r16();
    y_data_in = r16();
    data_read_bus_d_in = r16();
    lmem_high_in = r16();
    lmem_low_in = r16();
  endtask
  task automatic cmp(input logic [39:0] got, exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_acc(input logic [39:0] got, exp);
    cmp(got, exp);
  endtask
  task automatic chk_bit(input logic got, exp);
    cmp(40'(got), 40'(exp));
  endtask
  task automatic chk_word(input logic [15:0] got, exp);
    cmp(40'(got), 40'(exp));
  endtask
  task automatic compare();
    chk_acc(accumulator_a_out, ea);
    chk_acc(accumulator_b_out, eb);
    chk_bit(overflow_flag_dest_a_out, fa);
    chk_bit(overflow_flag_dest_b_out, fb);
    chk_word(coefficient_pointer_out, ep);
    chk_word(coef_addr_high_out, ep);
    chk_word(coef_addr_low_out, ep ^ 16'h0001);
    chk_word(16'(instr_size_out), 16'(es));
    chk_bit(instr_done_out, ed);
    chk_bit(instr_reject_out, er);
  endtask
  task automatic wrap_up();
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    void'($urandom(64));
    drive(0);
    repeat (3) @(posedge clk_in);
    #1;
    compare();
    for (int i = 0; i < 2000; i++) begin
      drive(1);
      srst_in = i == 1000;
      predict();
      @(posedge clk_in);
      #1;
      compare();
    end
    wrap_up();
  end
endmodule
